// [rtl/ptcd_defs.svh]
`ifndef PTCD_DEFS_SVH
`define PTCD_DEFS_SVH

// Address byte upper nibble, lower nibble comes from the straps
`define PTCD_DEV_ID      4'h5
// Instruction nibbles
`define PTCD_OP_GSTORE   4'h8
`define PTCD_OP_GRECALL  4'h1
`define PTCD_OP_STORE    4'he
`define PTCD_OP_RECALL   4'hd
`define PTCD_OP_INCDEC   4'h2
// Wiper range and reset value
`define PTCD_WIPER_MAX   6'h3f
`define PTCD_WIPER_MIN   6'h00
`define PTCD_WIPER_RST   6'h00
// Bit count at which the acknowledge bit is clocked
`define PTCD_ACK_BIT     4'h8
// Non-volatile write cycle time and core clock rate
`define PTCD_CLK_MHZ     40
`define PTCD_TWR_US      5000
`define PTCD_TWR_CYCLES  (`PTCD_TWR_US * `PTCD_CLK_MHZ)
// Host SCL divider phases (eight core clocks per SCL period)
`define PTCD_PH_DRIVE    3'h1
`define PTCD_PH_RISE     3'h3
`define PTCD_PH_MID      3'h5
`define PTCD_PH_FALL     3'h7
// SCL periods of idle bus before the host takes a command
`define PTCD_WARM_PERIODS 3'h4

`endif

// [rtl/ptcd_pkg.sv]
package ptcd_pkg;

    // Device link-side states
    typedef enum logic [3:0] {
        DS_IDLE  = 4'h1,
        DS_ADDR  = 4'h2,
        DS_INSTR = 4'h4,
        DS_STEP  = 4'h8
    } ptcd_dstate_e;

    // Host bit-engine states
    typedef enum logic [3:0] {
        HS_IDLE = 4'h1,
        HS_BYTE = 4'h2,
        HS_STEP = 4'h4,
        HS_STOP = 4'h8
    } ptcd_hstate_e;

    // Host command codes
    typedef enum logic [2:0] {
        OP_GSTORE  = 3'h0,
        OP_GRECALL = 3'h1,
        OP_STORE   = 3'h2,
        OP_RECALL  = 3'h3,
        OP_INCDEC  = 3'h4
    } ptcd_op_e;

    // Four six-bit wiper settings
    typedef logic [3:0][5:0] ptcd_wipers_t;

endpackage

// [rtl/ptcd_if.sv]
`timescale 1ns/10ps
interface ptcd_if;
    logic scl;
    logic sda_h_oe;
    logic sda_d_oe;
    wire  sda;

    // Open-drain SDA with pull-up: low whenever either end drives
    assign sda = !(sda_h_oe || sda_d_oe);

    modport host (output scl, output sda_h_oe, input sda);
    modport dev  (input scl, input sda, output sda_d_oe);
endinterface

// [rtl/ptcd_device.sv]
// Functional notes
// RULE1 - Global store copies all wipers to slot
// RULE2 - Single store copies one wiper to slot
// RULE3 - Single recall loads slot into one wiper
// RULE4 - Inc/dec: acked instruction, then direction bits, STOP
// RULE5 - Non-volatile cycle starts only after STOP
// RULE6 - High pulse steps wiper by SDA level
// RULE7 - Write-cycle counter bounds the store time
// RULE8 - Wiper saturates at steps 0 and 63
`timescale 1ns/10ps
`include "ptcd_defs.svh"
module ptcd_device #(
    parameter int unsigned NV_CYCLES = `PTCD_TWR_CYCLES
) (
    input  wire logic            clk,
    input  wire logic            rst_n,
    ptcd_if.dev                  link,
    input  wire logic [3:0]      addr_strap,
    output ptcd_pkg::ptcd_wipers_t wiper_setting_register,
    output logic                 nv_busy
);
    localparam int CW = $clog2(NV_CYCLES + 1);

    // START / STOP toggles, clocked by SDA edges while SCL is high
    logic start_tgl_reg;
    logic stop_tgl_reg;

    // SCL-domain state
    logic                   rst_q1, rst_q2;
    logic [3:0]             strap_q1, strap_q2;
    logic                   busy_q1, busy_q2;
    logic                   start_seen_reg, stop_seen_reg;
    ptcd_pkg::ptcd_dstate_e state_reg, state_next;
    logic [3:0]             cnt_reg;
    logic [7:0]             sh_reg;
    logic                   ack_oe_reg;
    logic                   step_pend_reg, step_up_reg;
    logic [1:0]             sel_pot_reg;
    logic [3:0]             pend_mask_reg;
    logic [1:0]             pend_slot_reg;
    ptcd_pkg::ptcd_wipers_t pend_data_reg;
    ptcd_pkg::ptcd_wipers_t wiper_next;
    logic                   req_tgl_reg;

    // Core-domain state
    logic          stop_q1, stop_q2, stop_q3;
    logic          req_q1, req_q2;
    logic          done_tgl_reg;
    logic [CW-1:0] nv_cnt_reg;
    logic [5:0]    slot_reg [16];

    // Frame markers
    always_ff @(negedge link.sda or negedge rst_n) begin
        if (!rst_n)
            start_tgl_reg <= 1'b0;
        else if (link.scl)
            start_tgl_reg <= ~start_tgl_reg;
    end

    always_ff @(posedge link.sda or negedge rst_n) begin
        if (!rst_n)
            stop_tgl_reg <= 1'b0;
        else if (link.scl)
            stop_tgl_reg <= ~stop_tgl_reg;
    end

    // Decode of the byte just shifted in
    wire       start_new  = start_tgl_reg ^ start_seen_reg;
    wire       stop_new   = stop_tgl_reg ^ stop_seen_reg;
    wire [3:0] op         = sh_reg[7:4];
    wire [1:0] pot        = sh_reg[3:2];
    wire [1:0] slt        = sh_reg[1:0];
    wire       at_ack     = (cnt_reg == `PTCD_ACK_BIT);
    wire       addr_hit   = (op == `PTCD_DEV_ID) && (sh_reg[3:0] == strap_q2) && !busy_q2;
    wire       is_gstore  = (op == `PTCD_OP_GSTORE) && (pot == 2'h0);  // [RULE1]
    wire       is_grecall = (op == `PTCD_OP_GRECALL) && (pot == 2'h0);
    wire       is_store   = (op == `PTCD_OP_STORE);                    // [RULE2]
    wire       is_recall  = (op == `PTCD_OP_RECALL);                   // [RULE3]
    wire       is_incdec  = (op == `PTCD_OP_INCDEC) && (slt == 2'h0);  // [RULE4]
    wire       instr_ok   = is_gstore || is_grecall || is_store || is_recall || is_incdec;
    wire       in_addr    = (state_reg == ptcd_pkg::DS_ADDR);
    wire       in_instr   = (state_reg == ptcd_pkg::DS_INSTR);
    wire       ack_now    = at_ack && ((in_addr && addr_hit) || (in_instr && instr_ok));
    wire       quiet      = !start_new && !stop_new;
    wire       cmd_go     = in_instr && at_ack && ack_oe_reg && quiet;
    wire       store_go   = cmd_go && (is_gstore || is_store);
    wire       recall_go  = cmd_go && (is_grecall || is_recall);
    wire       step_go    = (state_reg == ptcd_pkg::DS_STEP) && step_pend_reg && quiet;

    // State after the acknowledge bit, following what was actually driven
    always_comb begin
        if (!ack_oe_reg)
            state_next = ptcd_pkg::DS_IDLE;
        else if (in_addr)
            state_next = ptcd_pkg::DS_INSTR;
        else if (is_incdec)
            state_next = ptcd_pkg::DS_STEP;                        // [RULE4]
        else
            state_next = ptcd_pkg::DS_IDLE;
    end

    // Per-wiper next value: recall, saturating step, or hold
    for (genvar g = 0; g < 4; g++) begin : g_wiper
        wire [5:0] cur     = wiper_setting_register[g];
        wire       rc_sel  = recall_go && (is_grecall || pot == 2'(g));
        wire       st_sel  = step_go && (sel_pot_reg == 2'(g));
        wire [5:0] up_val  = (cur == `PTCD_WIPER_MAX) ? cur : cur + 6'h01;   // [RULE8]
        wire [5:0] dn_val  = (cur == `PTCD_WIPER_MIN) ? cur : cur - 6'h01;   // [RULE8]
        assign wiper_next[g] = rc_sel ? slot_reg[{2'(g), slt}] :             // [RULE3]
                               st_sel ? (step_up_reg ? up_val : dn_val) :    // [RULE6]
                               cur;
    end

    // Link-side reset: asserts at once, releases on the second rising SCL
    // (SCL stands still while the host is in reset, so no edge can be relied on)
    always_ff @(posedge link.scl or negedge rst_n) begin
        if (!rst_n) begin
            rst_q1 <= 1'b0;
            rst_q2 <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_q2 <= rst_q1;
        end
    end

    // Strap and busy synchronisers on SCL
    always_ff @(posedge link.scl) begin
        strap_q1 <= addr_strap;
        strap_q2 <= strap_q1;
        busy_q1  <= nv_busy;
        busy_q2  <= busy_q1;
    end

    // Frame sequencing and bit shifting
    always_ff @(posedge link.scl) begin
        if (!rst_q2) begin
            state_reg      <= ptcd_pkg::DS_IDLE;
            cnt_reg        <= 4'h0;
            sh_reg         <= 8'h00;
            start_seen_reg <= 1'b0;
            stop_seen_reg  <= 1'b0;
        end else begin
            start_seen_reg <= start_tgl_reg;
            stop_seen_reg  <= stop_tgl_reg;
            if (start_new) begin
                state_reg <= ptcd_pkg::DS_ADDR;
                cnt_reg   <= 4'h1;
                sh_reg    <= {7'h00, link.sda};
            end else if (stop_new) begin
                state_reg <= ptcd_pkg::DS_IDLE;
                cnt_reg   <= 4'h0;
            end else if ((in_addr || in_instr) && at_ack) begin
                state_reg <= state_next;
                cnt_reg   <= 4'h0;
            end else if (in_addr || in_instr) begin
                sh_reg  <= {sh_reg[6:0], link.sda};
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end

    // Direction bit is held one pulse; a STOP or START discards it
    always_ff @(posedge link.scl) begin
        if (!rst_q2 || !quiet || cmd_go) begin
            step_pend_reg <= 1'b0;
            step_up_reg   <= 1'b0;
        end else if (state_reg == ptcd_pkg::DS_STEP) begin
            step_pend_reg <= 1'b1;                                 // [RULE6]
            step_up_reg   <= link.sda;                             // [RULE6]
        end
    end

    // Wiper registers and pot selection, cleared as soon as reset asserts
    always_ff @(posedge link.scl or negedge rst_q2) begin
        if (!rst_q2) begin
            wiper_setting_register <= {4{`PTCD_WIPER_RST}};
            sel_pot_reg            <= 2'h0;
        end else begin
            wiper_setting_register <= wiper_next;
            if (cmd_go)
                sel_pot_reg <= pot;
        end
    end

    // Store request: snapshot waits for STOP in the core domain
    always_ff @(posedge link.scl) begin
        if (!rst_q2) begin
            pend_mask_reg <= 4'h0;
            pend_slot_reg <= 2'h0;
            pend_data_reg <= '0;
            req_tgl_reg   <= 1'b0;
        end else if (store_go) begin
            pend_mask_reg <= is_gstore ? 4'hf : (4'h1 << pot);     // [RULE1] [RULE2]
            pend_slot_reg <= slt;
            pend_data_reg <= wiper_setting_register;
            req_tgl_reg   <= ~req_tgl_reg;
        end
    end

    // Acknowledge driven from falling SCL for one bit time, SDA freed in reset
    always_ff @(negedge link.scl or negedge rst_q2) begin
        if (!rst_q2)
            ack_oe_reg <= 1'b0;
        else
            ack_oe_reg <= ack_now && quiet;                        // [RULE1] [RULE4]
    end

    assign link.sda_d_oe = ack_oe_reg;

    // STOP and request crossings into the core clock
    always_ff @(posedge clk) begin
        stop_q1 <= stop_tgl_reg;
        stop_q2 <= stop_q1;
        stop_q3 <= stop_q2;
        req_q1  <= req_tgl_reg;
        req_q2  <= req_q1;
    end

    wire stop_evt = stop_q2 ^ stop_q3;
    wire commit   = stop_evt && (req_q2 != done_tgl_reg);          // [RULE5]

    // Write cycle timer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_tgl_reg <= 1'b0;
            nv_busy      <= 1'b0;
            nv_cnt_reg   <= '0;
        end else if (commit) begin
            done_tgl_reg <= req_q2;
            nv_busy      <= 1'b1;
            nv_cnt_reg   <= CW'(NV_CYCLES - 1);                    // [RULE7]
        end else if (nv_busy) begin
            if (nv_cnt_reg == '0)
                nv_busy <= 1'b0;                                   // [RULE7]
            else
                nv_cnt_reg <= nv_cnt_reg - CW'(1);
        end
    end

    // Stored setting slots, index {pot, slot}
    always_ff @(posedge clk) begin
        for (int i = 0; i < 16; i++) begin
            if (!rst_n)
                slot_reg[i] <= `PTCD_WIPER_RST;
            else if (commit && pend_mask_reg[i / 4] && (pend_slot_reg == 2'(i)))
                slot_reg[i] <= pend_data_reg[i / 4];               // [RULE1] [RULE2] [RULE5]
        end
    end

endmodule

// [rtl/ptcd_host.sv]
`timescale 1ns/10ps
`include "ptcd_defs.svh"
module ptcd_host (
    input  wire logic              clk,
    input  wire logic              rst_n,
    ptcd_if.host                   link,
    input  wire logic [3:0]        address_strap_pins,
    input  wire logic              cmd_valid,
    input  ptcd_pkg::ptcd_op_e     cmd_op,
    input  wire logic [1:0]        pot_select_bits,
    input  wire logic [1:0]        slot_select_bits,
    input  wire logic [7:0]        cmd_steps,
    input  wire logic              cmd_up,
    output logic                   cmd_ready,
    output logic                   cmd_done,
    output logic                   cmd_nack
);
    ptcd_pkg::ptcd_hstate_e state_reg;
    logic [2:0] ph_reg;
    logic       scl_reg;
    logic       oe_reg;
    logic       sda_q1, sda_q2;
    logic [2:0] warm_reg;
    logic [7:0] sh_reg;
    logic [7:0] instr_reg;
    logic [3:0] bitn_reg;
    logic       second_reg;
    logic       inc_reg;
    logic       up_reg;
    logic [7:0] steps_reg;

    wire ph_drive = (ph_reg == `PTCD_PH_DRIVE);
    wire ph_mid   = (ph_reg == `PTCD_PH_MID);
    wire warm     = (warm_reg == `PTCD_WARM_PERIODS);
    wire idle     = (state_reg == ptcd_pkg::HS_IDLE);
    wire accept   = idle && warm && cmd_valid && ph_mid;            // [RULE1]
    wire at_ack   = (bitn_reg == `PTCD_ACK_BIT);

    // Instruction byte for each command
    wire [7:0] instr_byte =
        (cmd_op == ptcd_pkg::OP_GSTORE)  ? {`PTCD_OP_GSTORE, 2'h0, slot_select_bits} :  // [RULE1]
        (cmd_op == ptcd_pkg::OP_GRECALL) ? {`PTCD_OP_GRECALL, 2'h0, slot_select_bits} :
        (cmd_op == ptcd_pkg::OP_STORE)   ? {`PTCD_OP_STORE, pot_select_bits,
                                            slot_select_bits} :                          // [RULE2]
        (cmd_op == ptcd_pkg::OP_RECALL)  ? {`PTCD_OP_RECALL, pot_select_bits,
                                            slot_select_bits} :                          // [RULE3]
                                           {`PTCD_OP_INCDEC, pot_select_bits, 2'h0};     // [RULE4]

    // SCL divider, free running so the device sees edges at idle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ph_reg  <= 3'h0;
            scl_reg <= 1'b1;
        end else begin
            ph_reg <= ph_reg + 3'h1;
            if (ph_reg == `PTCD_PH_RISE)
                scl_reg <= 1'b1;
            else if (ph_reg == `PTCD_PH_FALL)
                scl_reg <= 1'b0;
        end
    end

    // SDA sampling and idle warm-up count
    always_ff @(posedge clk) begin
        sda_q1 <= link.sda;
        sda_q2 <= sda_q1;
        if (!rst_n)
            warm_reg <= 3'h0;
        else if (!warm && ph_reg == `PTCD_PH_FALL)
            warm_reg <= warm_reg + 3'h1;
    end

    // Frame engine
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg  <= ptcd_pkg::HS_IDLE;
            oe_reg     <= 1'b0;
            sh_reg     <= 8'h00;
            instr_reg  <= 8'h00;
            bitn_reg   <= 4'h0;
            second_reg <= 1'b0;
            inc_reg    <= 1'b0;
            up_reg     <= 1'b0;
            steps_reg  <= 8'h00;
            cmd_nack   <= 1'b0;
        end else begin
            case (state_reg)
                ptcd_pkg::HS_IDLE: begin
                    if (accept) begin
                        oe_reg     <= 1'b1;
                        sh_reg     <= {`PTCD_DEV_ID, address_strap_pins};
                        instr_reg  <= instr_byte;
                        bitn_reg   <= 4'h0;
                        second_reg <= 1'b0;
                        inc_reg    <= (cmd_op == ptcd_pkg::OP_INCDEC);
                        up_reg     <= cmd_up;
                        steps_reg  <= cmd_steps;
                        cmd_nack   <= 1'b0;
                        state_reg  <= ptcd_pkg::HS_BYTE;
                    end
                end
                ptcd_pkg::HS_BYTE: begin
                    if (ph_drive) begin
                        oe_reg <= at_ack ? 1'b0 : ~sh_reg[7];
                    end else if (ph_mid && !at_ack) begin
                        sh_reg   <= {sh_reg[6:0], 1'b0};
                        bitn_reg <= bitn_reg + 4'h1;
                    end else if (ph_mid) begin
                        bitn_reg <= 4'h0;
                        if (sda_q2) begin
                            cmd_nack  <= 1'b1;
                            state_reg <= ptcd_pkg::HS_STOP;
                        end else if (!second_reg) begin
                            second_reg <= 1'b1;
                            sh_reg     <= instr_reg;
                        end else if (inc_reg && steps_reg != 8'h00) begin
                            state_reg <= ptcd_pkg::HS_STEP;        // [RULE4]
                        end else begin
                            state_reg <= ptcd_pkg::HS_STOP;
                        end
                    end
                end
                ptcd_pkg::HS_STEP: begin
                    if (ph_drive) begin
                        oe_reg <= ~up_reg;                         // [RULE6]
                    end else if (ph_mid) begin
                        steps_reg <= steps_reg - 8'h01;
                        if (steps_reg == 8'h01)
                            state_reg <= ptcd_pkg::HS_STOP;        // [RULE4]
                    end
                end
                ptcd_pkg::HS_STOP: begin
                    if (ph_drive) begin
                        oe_reg <= 1'b1;
                    end else if (ph_mid) begin
                        oe_reg    <= 1'b0;                         // [RULE5]
                        state_reg <= ptcd_pkg::HS_IDLE;
                    end
                end
                default: state_reg <= ptcd_pkg::HS_IDLE;
            endcase
        end
    end

    // Handshake flags
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_ready <= 1'b0;
            cmd_done  <= 1'b0;
        end else begin
            cmd_ready <= idle && warm && !accept;
            cmd_done  <= (state_reg == ptcd_pkg::HS_STOP) && ph_mid;
        end
    end

    assign link.scl      = scl_reg;
    assign link.sda_h_oe = oe_reg;

endmodule

// [tb/ptcd_checker.sv]
`timescale 1ns/10ps
module ptcd_checker #(
    parameter int unsigned NV_CYCLES = 20
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              scl,
    input  wire logic              sda,
    input  wire logic              sda_d_oe,
    input  wire logic              nv_busy,
    input  wire logic              cmd_done,
    input  ptcd_pkg::ptcd_wipers_t wiper_setting_register
);
    logic        scl_d;
    logic        sda_d;
    logic        in_frame;
    logic [3:0]  bit_cnt;
    logic [7:0]  since_stop;
    logic [31:0] busy_cnt;
    wire         start_ev;
    wire         stop_ev;

    // Bus conditions seen from the sampled link
    assign start_ev = scl && scl_d && sda_d && !sda;
    assign stop_ev  = scl && scl_d && !sda_d && sda;

    // Frame, bit position and timers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_d      <= 1'b1;
            sda_d      <= 1'b1;
            in_frame   <= 1'b0;
            bit_cnt    <= 4'h0;
            since_stop <= 8'hff;
            busy_cnt   <= 32'h0;
        end else begin
            scl_d      <= scl;
            sda_d      <= sda;
            in_frame   <= start_ev ? 1'b1 : (stop_ev ? 1'b0 : in_frame);
            since_stop <= stop_ev ? 8'h00 : (since_stop == 8'hff ? since_stop : since_stop + 8'h01);
            busy_cnt   <= nv_busy ? busy_cnt + 32'h1 : 32'h0;
            if (start_ev) begin
                bit_cnt <= 4'h0;
            end else if (scl && !scl_d && in_frame) begin
                bit_cnt <= (bit_cnt == 4'h9) ? 4'h1 : bit_cnt + 4'h1;
            end
        end
    end

    // Link timing of the answering end
    a_ack_oe_steady: assert property (@(posedge clk) disable iff (!rst_n)
        scl && scl_d |-> $stable(sda_d_oe)) else $error("device sda moved while scl high");
    a_ack_starts_ninth: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(sda_d_oe) |-> in_frame && bit_cnt == 4'h8 && !scl)
        else $error("device ack began at wrong bit");
    a_ack_ends_ninth: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(sda_d_oe) && in_frame |-> bit_cnt == 4'h9 && !scl)
        else $error("device ack ended at wrong bit");
    a_oe_in_frame: assert property (@(posedge clk) disable iff (!rst_n)
        sda_d_oe |-> in_frame) else $error("device drove sda outside a frame");
    // Write cycle placement and length, wiper change only with SCL high, done after STOP
    a_nv_after_stop: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(nv_busy) |-> !in_frame && since_stop <= 8'd12)
        else $error("write cycle not started just after stop");
    a_nv_length: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(nv_busy) |-> busy_cnt == NV_CYCLES) else $error("write cycle length wrong");
    a_wiper_on_scl: assert property (@(posedge clk) disable iff (!rst_n)
        !$stable(wiper_setting_register) |-> scl) else $error("wiper moved with scl low");
    a_done_at_stop: assert property (@(posedge clk) disable iff (!rst_n)
        stop_ev |-> ##[0:3] cmd_done) else $error("no done after stop");
endmodule

// [tb/ptcd_tb.sv]
`timescale 1ns/10ps
module pot_transfer_command_decoder_tb;
    localparam int unsigned NV = 400;
    logic                   clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic [3:0]             strap = 4'ha;
    logic [3:0]             dev_strap = 4'ha;
    logic                   cmd_valid = 1'b0;
    ptcd_pkg::ptcd_op_e     cmd_op = ptcd_pkg::OP_INCDEC;
    logic [1:0]             pot_sel = 2'h0;
    logic [1:0]             slot_sel = 2'h0;
    logic [7:0]             cmd_steps = 8'h00;
    logic                   cmd_up = 1'b0;
    logic                   cmd_ready;
    logic                   cmd_done;
    logic                   cmd_nack;
    logic                   nv_busy;
    ptcd_pkg::ptcd_wipers_t wiper;
    logic [5:0]             exp_w [4] = '{6'h00, 6'h00, 6'h00, 6'h00};
    int                     mismatches = 0;
    int                     total_checks = 0;
    int                     cycles = 0;

    // Clock and the two ends joined by the link
    always #12.5 clk = ~clk;
    ptcd_if link ();
    ptcd_device #(.NV_CYCLES(NV)) i_ptcd_device (.clk(clk), .rst_n(rst_n), .link(link),
        .addr_strap(dev_strap), .wiper_setting_register(wiper), .nv_busy(nv_busy));
    ptcd_host i_ptcd_host (.clk(clk), .rst_n(rst_n), .link(link), .address_strap_pins(strap),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .pot_select_bits(pot_sel),
        .slot_select_bits(slot_sel), .cmd_steps(cmd_steps), .cmd_up(cmd_up),
        .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_nack(cmd_nack));
    ptcd_checker #(.NV_CYCLES(NV)) i_ptcd_checker (.clk(clk), .rst_n(rst_n), .scl(link.scl),
        .sda(link.sda), .sda_d_oe(link.sda_d_oe), .nv_busy(nv_busy), .cmd_done(cmd_done),
        .wiper_setting_register(wiper));

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_wipers();
        for (int g = 0; g < 4; g++) begin
            total_checks++;
            if (wiper[g] !== exp_w[g]) begin
                mismatches++;
                $display("Error at %0t: got %h expected %h", $time, wiper[g], exp_w[g]);
            end
        end
    endtask

    // One whole frame through the host command port
    task automatic send(input ptcd_pkg::ptcd_op_e op, input logic [1:0] pot,
                        input logic [1:0] slot, input logic [7:0] steps, input logic up,
                        input logic nack);
        int n;
        n = 0;
        @(negedge clk);
        while (cmd_ready !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        cmd_op = op;
        pot_sel = pot;
        slot_sel = slot;
        cmd_steps = steps;
        cmd_up = up;
        cmd_valid = 1'b1;
        while (cmd_ready === 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        cmd_valid = 1'b0;
        while (cmd_done !== 1'b1 && n < 6000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_flag(cmd_done, 1'b1);
        chk_flag(cmd_nack, nack);
        chk_flag(cmd_ready, 1'b0);
    endtask

    // Write cycle must begin after the frame and end on its own
    task automatic nv_rise();
        int n;
        chk_flag(nv_busy, 1'b0);
        n = 0;
        while (nv_busy !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_flag(nv_busy, 1'b1);
    endtask

    task automatic nv_fall();
        int n;
        n = 0;
        while (nv_busy !== 1'b0 && n < NV + 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_flag(nv_busy, 1'b0);
    endtask

    task automatic t_incdec();
        send(ptcd_pkg::OP_INCDEC, 2'h1, 2'h0, 8'd5, 1'b1, 1'b0);
        exp_w[1] = 6'h05;
        chk_wipers();
        send(ptcd_pkg::OP_INCDEC, 2'h1, 2'h0, 8'd70, 1'b1, 1'b0);
        exp_w[1] = 6'h3f;
        chk_wipers();
        send(ptcd_pkg::OP_INCDEC, 2'h1, 2'h0, 8'd3, 1'b0, 1'b0);
        exp_w[1] = 6'h3c;
        send(ptcd_pkg::OP_INCDEC, 2'h2, 2'h0, 8'd2, 1'b0, 1'b0);
        chk_wipers();
        $display("incdec test finished");
    endtask

    task automatic t_store_recall();
        send(ptcd_pkg::OP_STORE, 2'h1, 2'h2, 8'd0, 1'b0, 1'b0);
        nv_rise();
        send(ptcd_pkg::OP_INCDEC, 2'h1, 2'h0, 8'd4, 1'b0, 1'b1);
        chk_wipers();
        nv_fall();
        send(ptcd_pkg::OP_INCDEC, 2'h1, 2'h0, 8'd70, 1'b0, 1'b0);
        exp_w[1] = 6'h00;
        chk_wipers();
        send(ptcd_pkg::OP_RECALL, 2'h1, 2'h2, 8'd0, 1'b0, 1'b0);
        exp_w[1] = 6'h3c;
        chk_wipers();
        $display("store and recall test finished");
    endtask

    task automatic t_global();
        send(ptcd_pkg::OP_INCDEC, 2'h3, 2'h0, 8'd9, 1'b1, 1'b0);
        exp_w[3] = 6'h09;
        send(ptcd_pkg::OP_GSTORE, 2'h0, 2'h1, 8'd0, 1'b0, 1'b0);
        nv_rise();
        nv_fall();
        send(ptcd_pkg::OP_INCDEC, 2'h3, 2'h0, 8'd9, 1'b0, 1'b0);
        send(ptcd_pkg::OP_INCDEC, 2'h1, 2'h0, 8'd70, 1'b0, 1'b0);
        exp_w[1] = 6'h00;
        exp_w[3] = 6'h00;
        chk_wipers();
        send(ptcd_pkg::OP_GRECALL, 2'h0, 2'h1, 8'd0, 1'b0, 1'b0);
        exp_w[1] = 6'h3c;
        exp_w[3] = 6'h09;
        chk_wipers();
        send(ptcd_pkg::OP_RECALL, 2'h3, 2'h2, 8'd0, 1'b0, 1'b0);
        exp_w[3] = 6'h00;
        chk_wipers();
        $display("global test finished");
    endtask

    task automatic t_wrong_addr();
        @(negedge clk);
        strap = 4'h3;
        send(ptcd_pkg::OP_INCDEC, 2'h0, 2'h0, 8'd5, 1'b1, 1'b1);
        chk_wipers();
        @(negedge clk);
        dev_strap = 4'h3;
        send(ptcd_pkg::OP_INCDEC, 2'h0, 2'h0, 8'd5, 1'b1, 1'b0);
        exp_w[0] = 6'h05;
        chk_wipers();
        @(negedge clk);
        strap = 4'ha;
        dev_strap = 4'ha;
        $display("address test finished");
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            results();
        end
    end

    // Main sequence
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        t_incdec();
        t_store_recall();
        t_global();
        t_wrong_addr();
        results();
    end
endmodule
